// *** tac_alarm_comparator.sv ***
// tac_alarm_comparator: threshold alarm, status flag and register port
`timescale 1ns/10ps

// Overview of operation
// - comparator mode: alarm on filtered overtemperature
// - comparator alarm holds until filtered undertemperature
// - power-down keeps comparator alarm level
// - interrupt latch clears on read or power-down
// - after over, wait for under before next
// - after under, wait for over before next
// - mode cleared then set rearms for overtemperature
// - reset arms overtemperature detection
// - event needs consecutive matching conversions
// - depth codes give 1, 2, 4, 6
// - reading configuration clears the status flag
// - status flag is one sticky bit
// - every valid event sets status, mask ignored
// - interrupt drive needs mask 0, mode 1
// - conversions continue while alarm asserted
// - polarity bit: 0 active low, 1 high
// - alarm pin is open drain
// - mask bit floats the alarm pin
// - top three config bits reset zero, msb read-only
// - hot at power-up sets status after first conversion
// - compare 9-bit two's complement values
// - power-down stops conversions
module tac_alarm_comparator #(
   parameter logic [31:0] CONV_CYCLES =
      32'(tac_pkg::CONV_PERIOD_CYCLES)           // cycles per conversion
) (
   input  wire logic                        core_clk,  // 100 MHz clock
   input  wire logic                        reset,     // sync, active high
   input  wire tac_pkg::tac_bus_t           bus,       // register request
   output logic [tac_pkg::TEMP_W-1:0]       rd_data,   // read data, next cycle
   input  wire logic [tac_pkg::TEMP_W-1:0]  adc_temp,  // converter result
   output logic                             conv_run,  // converter enabled
   output logic                             zone_sel,  // 1 = remote sensor
   output tac_pkg::tac_pin_t                alarm_pin  // open-drain alarm
);
   import tac_pkg::*;

   typedef struct packed {
      tac_cfg_t          cfg;        // configuration register
      logic [TEMP_W-1:0] temp;       // last measured temperature
      logic [TEMP_W-1:0] lower;      // lower_threshold
      logic [TEMP_W-1:0] upper;      // upper set point
      logic              arm_over;   // watching for overtemperature
      logic              int_latch;  // latched interrupt request
      logic              sample;     // fresh temperature in temp
      logic [TEMP_W-1:0] rdata;      // read data register
      logic              run;        // conversions running
      logic              zone;       // registered zone select
      tac_pin_t          pin;        // registered pin drive
   } tac_state_t;

   tac_state_t st_r;
   tac_state_t st_nxt;

   logic conv_done;    // a conversion just completed
   logic event_valid;  // filtered event of the watched kind
   logic over_now;     // current result above upper set point
   logic under_now;    // current result below lower_threshold
   logic cond;         // condition the filter watches
   logic restart;      // filter must drop its count
   logic cfg_wr;       // write to configuration this cycle
   logic any_rd;       // read of any register this cycle
   logic cfg_rd;       // read of configuration this cycle
   logic asserted;     // logical alarm state before polarity
   tac_cfg_t wcfg;     // configuration write data view

   // the conversion clock runs unless powered down; the alarm has no say
   tac_conv_timer #(
      .PERIOD_CYCLES (CONV_CYCLES)
   ) u_timer (
      .core_clk (core_clk),
      .reset    (reset),
      .run      (st_r.run),
      .done     (conv_done)
   );

   // signed compares on the 9-bit values
   always_comb begin
      over_now  = $signed(st_r.temp) > $signed(st_r.upper);
      under_now = $signed(st_r.temp) < $signed(st_r.lower);
      // only the kind of event that is armed is counted
      cond      = st_r.arm_over ? over_now : under_now;
   end

   // request decode
   always_comb begin
      wcfg    = tac_cfg_t'(bus.wdata[CFG_W-1:0]);
      cfg_wr  = bus.wr && (bus.addr == ADDR_CONFIG);
      any_rd  = bus.rd;
      cfg_rd  = bus.rd && (bus.addr == ADDR_CONFIG);
      // a depth or mode change would make a partial count meaningless
      restart = cfg_wr && ((wcfg.depth != st_r.cfg.depth) ||
                           (wcfg.mode != st_r.cfg.mode));
   end

   tac_event_filter u_filter (
      .core_clk (core_clk),
      .reset    (reset),
      .sample   (st_r.sample),
      .cond     (cond),
      .restart  (restart),
      .depth    (st_r.cfg.depth),
      .valid    (event_valid)
   );

   // next state
   always_comb begin
      st_nxt        = st_r;
      st_nxt.sample = 1'b0;
      asserted      = 1'b0;

      // conversion result capture, held while powered down
      if (conv_done && !st_r.cfg.pd) begin
         st_nxt.temp   = adc_temp;
         st_nxt.sample = 1'b1;
      end

      // read data mux; reserved addresses read as zero
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_TEMP:   st_nxt.rdata = st_r.temp;
            ADDR_CONFIG: st_nxt.rdata = {1'b0, st_r.cfg};
            ADDR_LOWER:  st_nxt.rdata = st_r.lower;
            ADDR_UPPER:  st_nxt.rdata = st_r.upper;
            default:     st_nxt.rdata = RD_ZERO;
         endcase
      end

      // read side effects come first so a same-cycle event wins
      if (cfg_rd) begin
         st_nxt.cfg.sts = 1'b0;
      end
      if (any_rd && st_r.cfg.mode) begin
         st_nxt.cfg.sts   = 1'b0;
         st_nxt.int_latch = 1'b0;
      end

      // register writes; the status bit ignores write data
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_LOWER: st_nxt.lower = bus.wdata;
            ADDR_UPPER: st_nxt.upper = bus.wdata;
            ADDR_CONFIG: begin
               st_nxt.cfg.mask  = wcfg.mask;
               st_nxt.cfg.zone  = wcfg.zone;
               st_nxt.cfg.depth = wcfg.depth;
               st_nxt.cfg.output_polarity_select   = wcfg.output_polarity_select;
               st_nxt.cfg.mode  = wcfg.mode;
               st_nxt.cfg.pd    = wcfg.pd;
            end
            default: begin
            end
         endcase
      end

      // leaving interrupt mode drops a pending latch
      if (cfg_wr && !wcfg.mode) begin
         st_nxt.int_latch = 1'b0;
      end
      // mode cleared then set again: look for overtemperature next
      if (cfg_wr && wcfg.mode && !st_r.cfg.mode) begin
         st_nxt.arm_over = 1'b1;
      end
      // power-down entry in interrupt mode; comparator keeps its level
      if (cfg_wr && wcfg.pd && !st_r.cfg.pd && st_r.cfg.mode) begin
         st_nxt.cfg.sts   = 1'b0;
         st_nxt.int_latch = 1'b0;
      end

      // a filtered event flips the armed kind and sets the sticky flag;
      // it is applied last so it beats any clear in the same cycle
      if (event_valid && !st_r.cfg.pd && !restart) begin
         st_nxt.cfg.sts  = 1'b1;
         st_nxt.arm_over = !st_r.arm_over;
         if (st_r.cfg.mode) begin
            st_nxt.int_latch = 1'b1;
         end
      end

      st_nxt.run  = !st_nxt.cfg.pd;
      st_nxt.zone = st_nxt.cfg.zone;

      // comparator: asserted while armed for the way back down
      if (st_nxt.cfg.mode) begin
         asserted = st_nxt.int_latch && !st_nxt.cfg.mask;
      end else begin
         asserted = !st_nxt.arm_over;
      end

      // open drain: sink when the wanted level is low, else float
      st_nxt.pin.out = 1'b0;
      st_nxt.pin.oe  = !st_nxt.cfg.mask &&
                       (asserted != st_nxt.cfg.output_polarity_select);
   end

   // state register; reset arms for overtemperature in either mode
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_r           <= '0;
         st_r.cfg       <= tac_cfg_t'(CFG_RST);
         st_r.temp      <= TEMP_RST;
         st_r.lower     <= LOWER_RST;
         st_r.upper     <= UPPER_RST;
         st_r.arm_over  <= 1'b1;
         st_r.run       <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign rd_data   = st_r.rdata;
   assign conv_run  = st_r.run;
   assign zone_sel  = st_r.zone;
   assign alarm_pin = st_r.pin;

endmodule : tac_alarm_comparator

// *** tac_pkg.sv ***
// tac_pkg: constants, carrier types and helpers of the thermal alarm comparator
package tac_pkg;

   // data widths
   localparam int unsigned TEMP_W   = 9;      // two's complement, 0.5 C lsb
   localparam int unsigned ADDR_W   = 8;      // command byte width
   localparam int unsigned CFG_W    = 8;      // configuration register width
   localparam int unsigned CNT_W    = 3;      // consecutive event counter
   localparam int unsigned TIMER_W  = 32;     // conversion period counter

   // register addresses (command byte values)
   localparam logic [ADDR_W-1:0] ADDR_TEMP   = 8'h00;  // measured temperature
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h01;  // configuration
   localparam logic [ADDR_W-1:0] ADDR_LOWER  = 8'h02;  // lower_threshold
   localparam logic [ADDR_W-1:0] ADDR_UPPER  = 8'h03;  // upper set point

   // reset values
   localparam logic [TEMP_W-1:0] TEMP_RST  = 9'h000;   // 0 C
   localparam logic [TEMP_W-1:0] LOWER_RST = 9'h096;   // +75 C
   localparam logic [TEMP_W-1:0] UPPER_RST = 9'h0a0;   // +80 C
   localparam logic [CFG_W-1:0]  CFG_RST   = 8'h00;    // all extensions off
   localparam logic [TEMP_W-1:0] RD_ZERO   = 9'h000;   // reserved reads

   // filter depth codes and their conversion counts
   localparam logic [1:0]       FQ_CODE_1 = 2'h0;
   localparam logic [1:0]       FQ_CODE_2 = 2'h1;
   localparam logic [1:0]       FQ_CODE_4 = 2'h2;
   localparam logic [1:0]       FQ_CODE_6 = 2'h3;
   localparam logic [CNT_W-1:0] FQ_DEPTH_1 = 3'h1;
   localparam logic [CNT_W-1:0] FQ_DEPTH_2 = 3'h2;
   localparam logic [CNT_W-1:0] FQ_DEPTH_4 = 3'h4;
   localparam logic [CNT_W-1:0] FQ_DEPTH_6 = 3'h6;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE    = 3'h1;

   // timing: conversion_period in microseconds and its cycle count
   localparam int unsigned CLK_MHZ             = 100;
   localparam int unsigned CONV_PERIOD_US      = 100;
   localparam int unsigned CONV_PERIOD_CYCLES  = CONV_PERIOD_US * CLK_MHZ;
   localparam logic [TIMER_W-1:0] TIMER_ZERO   = 32'h0000_0000;
   localparam logic [TIMER_W-1:0] TIMER_ONE    = 32'h0000_0001;

   // configuration register layout, msb first
   typedef struct packed {
      logic       sts;     // event_status_flag, read only
      logic       mask;    // alarm_mask, 1 floats the pin
      logic       zone;    // sensor zone select, 1 = remote
      logic [1:0] depth;   // filter depth code
      logic       output_polarity_select;     // output_polarity_select, 1 = active high
      logic       mode;    // 1 = interrupt, 0 = comparator
      logic       pd;      // power_down_bit
   } tac_cfg_t;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;   // register address
      logic [TEMP_W-1:0] wdata;  // write data, low bits for config
      logic              wr;     // write strobe
      logic              rd;     // read strobe
   } tac_bus_t;

   // open-drain pin drive
   typedef struct packed {
      logic out;   // level driven, always low for open drain
      logic oe;    // high while sinking
   } tac_pin_t;

   // depth code to number of consecutive conversions
   function automatic logic [CNT_W-1:0] tac_fq_depth(input logic [1:0] code);
      logic [CNT_W-1:0] d;
      d = FQ_DEPTH_1;
      unique case (code)
         FQ_CODE_1: d = FQ_DEPTH_1;
         FQ_CODE_2: d = FQ_DEPTH_2;
         FQ_CODE_4: d = FQ_DEPTH_4;
         FQ_CODE_6: d = FQ_DEPTH_6;
      endcase
      return d;
   endfunction : tac_fq_depth

endpackage : tac_pkg

// *** tac_conv_timer.sv ***
// tac_conv_timer: one-cycle conversion done pulse every conversion period
`timescale 1ns/10ps
module tac_conv_timer #(
   parameter logic [31:0] PERIOD_CYCLES =
      32'(tac_pkg::CONV_PERIOD_CYCLES)               // cycles per conversion
) (
   input  wire logic core_clk,   // system clock
   input  wire logic reset,      // synchronous, active high
   input  wire logic run,        // conversions enabled
   output logic      done        // pulse when a conversion completes
);
   import tac_pkg::*;

   typedef struct packed {
      logic [TIMER_W-1:0] count;
      logic               done;
   } tac_timer_st_t;

   tac_timer_st_t st_r;
   tac_timer_st_t st_nxt;

   // a stopped timer restarts from zero, so the first result after
   // leaving power-down takes a whole period
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      if (!run) begin
         st_nxt.count = TIMER_ZERO;
      end else if (st_r.count == PERIOD_CYCLES - TIMER_ONE) begin
         st_nxt.count = TIMER_ZERO;
         st_nxt.done  = 1'b1;
      end else begin
         st_nxt.count = st_r.count + TIMER_ONE;
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign done = st_r.done;

endmodule : tac_conv_timer

// *** tac_event_filter.sv ***
// tac_event_filter: counts consecutive conversions that meet a condition
`timescale 1ns/10ps
module tac_event_filter (
   input  wire logic       core_clk,  // system clock
   input  wire logic       reset,     // synchronous, active high
   input  wire logic       sample,    // a new result is ready this cycle
   input  wire logic       cond,      // result meets the watched condition
   input  wire logic       restart,   // drop any partial count
   input  wire logic [1:0] depth,     // filter depth code
   output logic            valid      // pulse: condition held long enough
);
   import tac_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             valid;
   } tac_filt_st_t;

   tac_filt_st_t st_r;
   tac_filt_st_t st_nxt;

   // restart beats a sample so a stale count never fires an event
   always_comb begin
      st_nxt       = st_r;
      st_nxt.valid = 1'b0;
      if (restart) begin
         st_nxt.count = CNT_ZERO;
      end else if (sample) begin
         if (!cond) begin
            st_nxt.count = CNT_ZERO;
         end else if (st_r.count + CNT_ONE >= tac_fq_depth(depth)) begin
            st_nxt.count = CNT_ZERO;
            st_nxt.valid = 1'b1;
         end else begin
            st_nxt.count = st_r.count + CNT_ONE;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign valid = st_r.valid;

endmodule : tac_event_filter

// *** tac_far_model.sv ***
// tac_far_model: sensor front end and pulled-up alarm line beside the block
`timescale 1ns/10ps
module tac_far_model (
   input  wire logic              core_clk,  // system clock
   input  wire logic              conv_run,  // converter enabled
   input  wire logic [8:0]        temp_set,  // temperature to present
   input  wire tac_pkg::tac_pin_t alarm_pin, // open-drain drive
   output logic [8:0]             adc_temp,  // converter result
   output logic                   pin_lvl    // resolved line level
);
   import tac_pkg::*;
   logic [8:0] junk_r = 9'h155;  // idle pattern
   // a stopped converter has no valid result, so show a moving pattern
   always @(posedge core_clk) junk_r <= ~junk_r;
   assign adc_temp = (conv_run === 1'h0) ? junk_r : temp_set;
   // the pull-up wins unless the block sinks the line
   assign pin_lvl = alarm_pin.oe ? alarm_pin.out : 1'h1;
endmodule : tac_far_model

// *** tac_alarm_comparator_monitor.sv ***
// tac_alarm_comparator_monitor: concurrent checks at the block's ports
`timescale 1ns/10ps
module tac_alarm_comparator_monitor (
   input wire logic                       core_clk,  // system clock
   input wire logic                       reset,     // sync, active high
   input wire tac_pkg::tac_bus_t          bus,       // register request
   input wire logic [tac_pkg::TEMP_W-1:0] rd_data,   // read data
   input wire logic [tac_pkg::TEMP_W-1:0] adc_temp,  // converter result
   input wire logic                       conv_run,  // converter enable
   input wire logic                       zone_sel,  // zone select
   input wire tac_pkg::tac_pin_t          alarm_pin  // alarm drive
);
   import tac_pkg::*;
   tac_cfg_t          cfg_r;    // written configuration, status left out
   logic [TEMP_W-1:0] lower_r;  // written lower_threshold
   // shadows follow host writes only
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_r   <= CFG_RST;
         lower_r <= LOWER_RST;
      end else if (bus.wr && bus.addr == ADDR_CONFIG) begin
         cfg_r   <= {1'h0, bus.wdata[6:0]};
      end else if (bus.wr && bus.addr == ADDR_LOWER) begin
         lower_r <= bus.wdata;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // power-down entered long ago, so no event is still in flight
   sequence pd_quiet_s;
      cfg_r.pd && $past(cfg_r.pd, 5) && !bus.wr && !$past(bus.wr)
         && !$past(bus.wr, 2);
   endsequence
   sequence cfg_read_s;
      bus.rd && bus.addr == ADDR_CONFIG;
   endsequence
   sequence low_read_s;
      bus.rd && bus.addr == ADDR_LOWER;
   endsequence
   open_drain_a: assert property (alarm_pin.out == 1'h0)
      else $error("alarm pin drives high");
   mask_float_a: assert property (cfg_r.mask |=> !alarm_pin.oe)
      else $error("masked alarm pin sinks");
   pd_keep_a: assert property (
      pd_quiet_s ##0 !cfg_r.mode |=> $stable(alarm_pin.oe))
      else $error("comparator pin moved in power-down");
   int_pd_a: assert property (
      pd_quiet_s ##0 cfg_r.mode |-> alarm_pin.oe == (cfg_r.output_polarity_select && !cfg_r.mask))
      else $error("interrupt pin not released in power-down");
   run_follow_a: assert property (
      cfg_r.pd == $past(cfg_r.pd) |-> conv_run == !cfg_r.pd)
      else $error("converter enable disagrees with power-down");
   zone_follow_a: assert property (
      cfg_r.zone == $past(cfg_r.zone) |-> zone_sel == cfg_r.zone)
      else $error("zone select disagrees with configuration");
   cfg_read_a: assert property (
      cfg_read_s |=> !rd_data[8] && rd_data[6:0] == $past(cfg_r[6:0]))
      else $error("configuration read returned wrong bits");
   low_read_a: assert property (
      low_read_s |=> rd_data == $past(lower_r))
      else $error("lower threshold read returned wrong value");
   reset_idle_a: assert property (
      $fell(reset) |-> conv_run && !zone_sel && !alarm_pin.oe)
      else $error("outputs not idle after reset");
endmodule : tac_alarm_comparator_monitor

bind tac_alarm_comparator tac_alarm_comparator_monitor u_monitor (
   .core_clk (core_clk), .reset (reset), .bus (bus), .rd_data (rd_data),
   .adc_temp (adc_temp), .conv_run (conv_run), .zone_sel (zone_sel),
   .alarm_pin (alarm_pin));

// *** tb_thermal_alarm_comparator.sv ***
// tb_thermal_alarm_comparator: random and corner checks of the alarm block
`timescale 1ns/10ps
module tb_thermal_alarm_comparator;
   import tac_pkg::*;
   localparam int CC = 20;      // shortened conversion period
   logic       core_clk = 1'h0; // 100 MHz clock
   logic       reset    = 1'h1; // sync reset
   tac_bus_t   bus      = '0;   // register request
   logic [8:0] temp_set = '0;   // temperature shown to the block
   logic [8:0] rd_data;         // read data
   logic [8:0] adc_temp;        // converter result
   logic [8:0] hot;             // above the upper set point
   logic [8:0] cold;            // below lower_threshold
   logic       conv_run;        // converter enable
   logic       zone_sel;        // zone select
   logic       pin_lvl;         // line level with pull-up
   tac_pin_t   alarm_pin;       // pin drive
   int         errors   = 0;    // mismatches
   int         n_checks = 0;    // comparisons
   int         seed     = 32'hc64a;
   int         ph       = 0;    // guessed conversion timer phase

   always #5 core_clk = ~core_clk;
   // mirrors the timer so checks land mid-period, far from pin updates
   always @(posedge core_clk)
      ph <= (reset || !conv_run || ph == CC - 1) ? 0 : ph + 1;

   tac_alarm_comparator #(.CONV_CYCLES(32'(CC))) dut (
      .core_clk (core_clk), .reset (reset), .bus (bus), .rd_data (rd_data),
      .adc_temp (adc_temp), .conv_run (conv_run), .zone_sel (zone_sel),
      .alarm_pin (alarm_pin));
   tac_far_model far (
      .core_clk (core_clk), .conv_run (conv_run), .temp_set (temp_set),
      .alarm_pin (alarm_pin), .adc_temp (adc_temp), .pin_lvl (pin_lvl));

   // expected line level: mask floats it, else polarity picks the sense
   function automatic logic lvl(input logic on, input logic output_polarity_select,
                                input logic msk);
      return msk ? 1'h1 : (on ? output_polarity_select : ~output_polarity_select);
   endfunction : lvl

   task automatic report_and_stop;
      $display("checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_pin(input logic e);
      chk({8'h00, pin_lvl}, {8'h00, e});
   endtask : chk_pin

   task automatic wr(input logic [7:0] a, input logic [8:0] v);
      @(posedge core_clk);
      bus <= '{a, v, 1'h1, 1'h0};
      @(posedge core_clk);
      bus.wr <= 1'h0;
   endtask : wr

   // read data appears after the read edge and holds until the next read
   task automatic rdc(input logic [7:0] a, input logic [8:0] e);
      @(posedge core_clk);
      bus <= '{a, 9'h000, 1'h0, 1'h1};
      @(posedge core_clk);
      bus.rd <= 1'h0;
      #1 chk(rd_data, e);
   endtask : rdc

   // show t for exactly n conversions, starting mid-period
   task automatic step(input logic [8:0] t, input int n);
      int k;
      // no conversions wanted: leave the shown value alone
      if (n == 0)
         return;
      for (k = 0; k < 40 && ph != 8; k++)
         @(posedge core_clk);
      if (ph != 8) begin
         errors++;
         report_and_stop;
      end else begin
         temp_set <= t;
         repeat (n * CC) @(posedge core_clk);
      end
   endtask : step

   initial begin
      int i;
      int dep;
      hot  = 9'h033 + 9'($random(seed) & 7);
      cold = 9'h1cd - 9'($random(seed) & 7);
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      // reset values, then a reserved address
      rdc(ADDR_CONFIG, {1'h0, CFG_RST});
      rdc(ADDR_UPPER, UPPER_RST);
      rdc(8'(($random(seed) & 32'hff) | 32'h04), RD_ZERO);
      chk_pin(lvl(1'h0, 1'h0, 1'h0));
      // thresholds either side of zero catch an unsigned compare
      wr(ADDR_LOWER, 9'h1ce);
      wr(ADDR_UPPER, 9'h032);
      rdc(ADDR_LOWER, 9'h1ce);
      // comparator mode, every depth code, a miss in mid-count
      for (i = 0; i < 4; i++) begin
         dep = (i == 3) ? 6 : (1 << i);
         wr(ADDR_CONFIG, 9'(i << 3));
         step(hot, dep - 1);
         step(9'h032, 1);
         step(hot, dep - 1);
         chk_pin(lvl(1'h0, 1'h0, 1'h0));
         step(hot, 1);
         chk_pin(lvl(1'h1, 1'h0, 1'h0));
         rdc(ADDR_CONFIG, 9'(i << 3) | 9'h080);
         rdc(ADDR_CONFIG, 9'(i << 3));
         step(9'h000, 2);
         step(cold, dep - 1);
         chk_pin(lvl(1'h1, 1'h0, 1'h0));
         step(cold, 1);
         chk_pin(lvl(1'h0, 1'h0, 1'h0));
      end
      // comparator level survives power-down, converter stops
      wr(ADDR_CONFIG, 9'h000);
      step(hot, 1);
      wr(ADDR_CONFIG, 9'h001);
      temp_set <= cold;
      repeat (3 * CC) @(posedge core_clk);
      chk_pin(lvl(1'h1, 1'h0, 1'h0));
      rdc(ADDR_TEMP, hot);
      chk({8'h00, conv_run}, 9'h000);
      wr(ADDR_CONFIG, 9'h000);
      step(cold, 1);
      chk_pin(lvl(1'h0, 1'h0, 1'h0));
      // interrupt mode, active-high sense
      wr(ADDR_CONFIG, 9'h006);
      step(hot, 1);
      chk_pin(lvl(1'h1, 1'h1, 1'h0));
      step(9'h000, 2);
      chk_pin(lvl(1'h1, 1'h1, 1'h0));
      rdc(ADDR_TEMP, 9'h000);
      step(hot, 2);
      chk_pin(lvl(1'h0, 1'h1, 1'h0));
      rdc(ADDR_CONFIG, 9'h006);
      step(cold, 1);
      rdc(ADDR_CONFIG, 9'h086);
      step(cold, 2);
      chk_pin(lvl(1'h0, 1'h1, 1'h0));
      step(hot, 1);
      step(cold, 1);
      rdc(ADDR_CONFIG, 9'h086);
      // armed for under; toggling the mode bit rearms for over
      step(hot, 1);
      rdc(ADDR_TEMP, hot);
      wr(ADDR_CONFIG, 9'h004);
      wr(ADDR_CONFIG, 9'h006);
      step(hot, 1);
      chk_pin(lvl(1'h1, 1'h1, 1'h0));
      wr(ADDR_CONFIG, 9'h007);
      repeat (8) @(posedge core_clk);
      chk_pin(lvl(1'h0, 1'h1, 1'h0));
      rdc(ADDR_CONFIG, 9'h007);
      // masked line floats even with a pending event
      wr(ADDR_CONFIG, 9'h042);
      step(cold, 1);
      chk_pin(lvl(1'h1, 1'h0, 1'h1));
      rdc(ADDR_CONFIG, 9'h0c2);
      wr(ADDR_CONFIG, 9'h020);
      rdc(ADDR_CONFIG, 9'h020);
      chk({8'h00, zone_sel}, 9'h001);
      // hot at power-up: status after the first conversion
      @(posedge core_clk);
      temp_set <= 9'h0a1;
      reset    <= 1'h1;
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      step(9'h0a1, 1);
      chk_pin(lvl(1'h1, 1'h0, 1'h0));
      rdc(ADDR_CONFIG, 9'h080);
      chk({8'h00, zone_sel}, 9'h000);
      chk({8'h00, conv_run}, 9'h001);
      report_and_stop;
   end
endmodule : tb_thermal_alarm_comparator
